//--- logic/adc_conversion_control.sv
// second control register of the converter and its conversion start logic
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "conv_ctl_cfg.svh"
////////////////////////////////////////////////////////////////////////////
// overview
// - two software registers: control two and sample time upper
// - control two drives the converter core control levels directly, sample time upper the sample fields
// - start and wake are one-cycle pulses to the core, dma a one-cycle request to the dma controller
// - calibration bits are set by software, cleared by hardware
// - trigger pins cross in through three flops each
// - a pin change counts once stages two and three agree
// limitations
// - stabilization after wake is left to software timing
// - the core must pulse its done lines for one cycle only
// - a done pulse that never comes leaves a calibration bit set
// - software start bit stays set while selector is not software
// - an exact rewrite only starts while power is already on
// trade-offs
// - rewrite compare uses the masked word, so reserved bits
//   written as ones still count as an unchanged rewrite
// - three flop crossing costs about four cycles of trigger latency
//   but keeps a glitching pin from firing a false conversion
// - read data is registered to keep every output on a flop
////////////////////////////////////////////////////////////////////////////
module adc_conversion_control
(
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic [`ADDR_W-1:0]           addr,
  input  wire conv_ctl_pkg::word_t          wdata,
  input  wire logic                         wr_stb,
  input  wire logic                         rd_stb,
  output conv_ctl_pkg::word_t               rdata,
  input  wire logic [`TRIG_IN_W-1:0]        trig_in,
  input  wire logic                         core_conv_done,
  input  wire logic                         core_cal_init_done,
  input  wire logic                         core_cal_done,
  output logic                              core_wake,
  output logic                              core_power_on,
  output logic                              core_conv_start,
  output logic                              core_cal_init,
  output logic                              core_cal_run,
  output logic                              core_align_msb,
  output logic                              core_temp_ref_en,
  output logic [2:0]                        core_sample_ch16,
  output logic [2:0]                        core_sample_ch17,
  output logic                              dma_req
);
  import conv_ctl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  word_t                      ctl_q;          // control register two
  word_t                      ctl_d;
  word_t                      samp_q;         // sample time upper
  word_t                      samp_d;
  word_t                      rdata_q;        // read data, one cycle after strobe
  word_t                      rdata_d;
  cal_state_e                 cal_q;          // calibration sequencer
  cal_state_e                 cal_d;
  logic [`TRIG_IN_W-1:0]      trig_s1_q;      // pin synchroniser stages
  logic [`TRIG_IN_W-1:0]      trig_s2_q;
  logic [`TRIG_IN_W-1:0]      trig_s3_q;
  logic [`TRIG_IN_W-1:0]      trig_lvl_q;     // filtered trigger levels
  logic [`TRIG_IN_W-1:0]      trig_lvl_d;
  logic                       wake_q;         // one-cycle wake pulse
  logic                       wake_d;
  logic                       start_q;        // one-cycle conversion start
  logic                       start_d;
  logic                       dma_q;          // dma request pulse
  logic                       dma_d;
  logic                       wr_ctl;         // decoded write to control
  logic                       wr_samp;        // decoded write to sample time
  logic                       trig_edge;      // selected hardware trigger rose
  logic [`TRIG_SEL_W-1:0]     trig_sel;
  word_t                      wr_val;         // masked write value

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  always_comb
  begin
    wr_ctl  = 1'b0;
    wr_samp = 1'b0;
    if (wr_stb && addr == `OFF_CTL_TWO)
    begin
      wr_ctl = 1'b1;
    end
    else if (wr_stb && addr == `OFF_SAMPT_UPPER)
    begin
      wr_samp = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger input filtering: a change counts once stages two and three agree
  always_comb
  begin
    for (int i = 0; i < `TRIG_IN_W; i++)
    begin
      trig_lvl_d[i] = (trig_s2_q[i] == trig_s3_q[i]) ? trig_s3_q[i] : trig_lvl_q[i];
    end
  end

  // hardware trigger edge of the selected source, external trigger enabled
  always_comb
  begin
    trig_sel  = ctl_q[`TRIG_MSB:`TRIG_LSB];
    trig_edge = 1'b0;
    // reserved and software codes never take a pin edge
    if (ctl_q[`BIT_TRIG_EN] && trig_sel != `TRIG_SOFTWARE && trig_sel != `TRIG_RESERVED)
    begin
      trig_edge = trig_lvl_d[trig_sel] && !trig_lvl_q[trig_sel];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register, start, wake and calibration next state
  always_comb
  begin
    ctl_d   = ctl_q;
    samp_d  = samp_q;
    cal_d   = cal_q;
    wake_d  = 1'b0;
    start_d = 1'b0;
    dma_d   = 1'b0;
    wr_val  = wdata & `CTL_TWO_RW_MASK;
    // software write; reserved bits stay zero
    if (wr_ctl)
    begin
      ctl_d = wr_val;
      // rising edge of power bit wakes the core
      if (wr_val[`BIT_POWER_ON] && !ctl_q[`BIT_POWER_ON])
      begin
        wake_d = 1'b1;
      end
      // identical rewrite with power on starts a conversion
      else if (wr_val[`BIT_POWER_ON] && wr_val == ctl_q)
      begin
        start_d = 1'b1;
      end
      // writing zero cannot abort a running calibration
      ctl_d[`BIT_CAL_RESET] = ctl_q[`BIT_CAL_RESET] | wr_val[`BIT_CAL_RESET];
      ctl_d[`BIT_CAL_START] = ctl_q[`BIT_CAL_START] | wr_val[`BIT_CAL_START];
    end
    if (wr_samp)
    begin
      samp_d = wdata & `SAMPT_UPPER_MASK;
    end
    // software start bit launches when selector is software
    if (ctl_q[`BIT_SW_START] && ctl_q[`TRIG_MSB:`TRIG_LSB] == `TRIG_SOFTWARE
        && ctl_q[`BIT_POWER_ON])
    begin
      start_d              = 1'b1;
      ctl_d[`BIT_SW_START] = wr_ctl & wr_val[`BIT_SW_START];
    end
    // hardware trigger edge
    if (trig_edge && ctl_q[`BIT_POWER_ON])
    begin
      start_d = 1'b1;
    end
    // continuous restart after each finished conversion
    if (core_conv_done && ctl_q[`BIT_CONTINUOUS] && ctl_q[`BIT_POWER_ON])
    begin
      start_d = 1'b1;
    end
    // result hand-off to dma only when enabled
    if (core_conv_done && ctl_q[`BIT_DMA_EN])
    begin
      dma_d = 1'b1;
    end
    // calibration sequencer
    case (cal_q)
      CAL_IDLE:
      begin
        if (ctl_q[`BIT_CAL_RESET])
        begin
          cal_d = CAL_RESETTING;
        end
        else if (ctl_q[`BIT_CAL_START])
        begin
          cal_d = CAL_RUNNING;
        end
      end
      CAL_RESETTING:
      begin
        // bit stays one until init finishes
        if (core_cal_init_done)
        begin
          ctl_d[`BIT_CAL_RESET] = 1'b0;
          cal_d                 = CAL_IDLE;
        end
      end
      CAL_RUNNING:
      begin
        // cleared on completion, software polls for zero
        if (core_cal_done)
        begin
          ctl_d[`BIT_CAL_START] = 1'b0;
          cal_d                 = CAL_IDLE;
        end
      end
      default:
      begin
        cal_d = CAL_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_d = '0;
    if (rd_stb && addr == `OFF_CTL_TWO)
    begin
      rdata_d = ctl_q;
    end
    else if (rd_stb && addr == `OFF_SAMPT_UPPER)
    begin
      rdata_d = samp_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  // synchroniser stages carry no reset: the filter stage masks
  // whatever they hold until stages two and three agree
  // everything else clears on the synchronous reset
  // pulses restart at zero so no false start follows reset
  // filtered trigger levels reset low, the idle level of the pins,
  // so a pin already low after reset shows no edge
  // hazard: a pin held high through reset gives one edge after it
  // if its selector and trigger enable are already set
  // they never are, since control two resets to zero
  // cal sequencer returns to idle on reset with both bits clear
  // read data returns to zero, matching an idle read
  always_ff @(posedge mclk)
  begin
    trig_s1_q <= trig_in;
    trig_s2_q <= trig_s1_q;
    trig_s3_q <= trig_s2_q;
    if (rst)
    begin
      ctl_q      <= `RST_CTL_TWO;
      samp_q     <= `RST_SAMPT_UPPER;
      rdata_q    <= '0;
      cal_q      <= CAL_IDLE;
      trig_lvl_q <= '0;
      wake_q     <= 1'b0;
      start_q    <= 1'b0;
      dma_q      <= 1'b0;
    end
    else
    begin
      ctl_q      <= ctl_d;
      samp_q     <= samp_d;
      rdata_q    <= rdata_d;
      cal_q      <= cal_d;
      trig_lvl_q <= trig_lvl_d;
      wake_q     <= wake_d;
      start_q    <= start_d;
      dma_q      <= dma_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops; software owns stabilization timing
  // levels mirror control bits, pulses come from their own flops
  // power level lets the core keep itself awake between pulses
  // calibration levels stand until the core reports completion
  // sample time fields go to the core without further decode
  // no combinational path reaches any port from an input
  // keeping outputs registered adds one cycle to every answer
  // but removes timing paths through the core side
  // dma request is a single pulse per finished conversion
  // the dma controller must count pulses, not levels
  // wake pulse marks only the rising edge of the power bit
  assign rdata            = rdata_q;
  assign core_wake        = wake_q;
  assign core_power_on    = ctl_q[`BIT_POWER_ON];
  assign core_conv_start  = start_q;
  assign core_cal_init    = ctl_q[`BIT_CAL_RESET];
  assign core_cal_run     = ctl_q[`BIT_CAL_START];
  assign core_align_msb   = ctl_q[`BIT_ALIGN];
  assign core_temp_ref_en = ctl_q[`BIT_TEMP_REF_EN];
  assign core_sample_ch16 = samp_q[`SPT16_MSB:`SPT16_LSB];
  assign core_sample_ch17 = samp_q[`SPT17_MSB:`SPT17_LSB];
  assign dma_req          = dma_q;
endmodule

//--- inc/conv_ctl_cfg.svh
// register map, field positions and reset values for the conversion control block
`ifndef CONV_CTL_CFG_SVH
`define CONV_CTL_CFG_SVH
`define ADDR_W            8
`define OFF_CTL_TWO       8'h08
`define OFF_SAMPT_UPPER   8'h0C
`define RST_CTL_TWO       32'h0000_0000
`define RST_SAMPT_UPPER   32'h0000_0000
`define CTL_TWO_RW_MASK   32'h00DE_090F
`define SAMPT_UPPER_MASK  32'h00FC_0000
`define BIT_POWER_ON      0
`define BIT_CONTINUOUS    1
`define BIT_CAL_START     2
`define BIT_CAL_RESET     3
`define BIT_DMA_EN        8
`define BIT_ALIGN         11
`define TRIG_LSB          17
`define TRIG_MSB          19
`define BIT_TRIG_EN       20
`define BIT_SW_START      22
`define BIT_TEMP_REF_EN   23
`define TRIG_SOFTWARE     3'h7
`define TRIG_RESERVED     3'h3
`define TRIG_SEL_W        3
`define TRIG_IN_W         8
`define SPT16_LSB         18
`define SPT16_MSB         20
`define SPT17_LSB         21
`define SPT17_MSB         23
`endif

//--- inc/conv_ctl_pkg.sv
// types shared by the conversion control block
package conv_ctl_pkg;
  typedef enum logic [1:0] {CAL_IDLE, CAL_RESETTING, CAL_RUNNING} cal_state_e;
  typedef logic [31:0] word_t;
endpackage

//--- verification/conv_ctl_chk.sv
// concurrent checks on the conversion control ports
`timescale 1ns/1ps
`include "conv_ctl_cfg.svh"
module conv_ctl_chk
  import conv_ctl_pkg::*;
(
  input wire logic                mclk,
  input wire logic                rst,
  input wire logic [`ADDR_W-1:0]  addr,
  input wire conv_ctl_pkg::word_t wdata,
  input wire logic                wr_stb,
  input wire logic                rd_stb,
  input wire conv_ctl_pkg::word_t rdata,
  input wire logic                core_conv_done,
  input wire logic                core_cal_init_done,
  input wire logic                core_cal_done,
  input wire logic                core_wake,
  input wire logic                core_power_on,
  input wire logic                core_conv_start,
  input wire logic                core_cal_init,
  input wire logic                core_cal_run,
  input wire logic                dma_req
);
  word_t ctl_q;  // mirror of bits only software changes
  logic  wr_ctl; // write to the control word
  assign wr_ctl = wr_stb && addr == `OFF_CTL_TWO;
  // self-clearing bits left out: hardware owns them
  always_ff @(posedge mclk)
    if (rst)
      ctl_q <= '0;
    else if (wr_ctl)
      ctl_q <= wdata & 32'h009E_0903;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sw_start_a: assert property (
    wr_ctl && wdata[22] && wdata[19:17] == 3'h7 && core_power_on |-> ##[1:3] core_conv_start)
    else $error("software start lost");
  dma_gate_a: assert property (
    dma_req == $past(core_conv_done && ctl_q[8])) else $error("dma request wrong");
  cal_set_a: assert property (
    $rose(core_cal_init) |-> $past(wr_ctl && wdata[3])) else $error("init without write");
  cal_clear_a: assert property (
    core_cal_init && core_cal_init_done |=> !core_cal_init) else $error("init not cleared");
  cal_read_a: assert property (
    rd_stb && addr == `OFF_CTL_TWO |=> rdata[3] == $past(core_cal_init)
      && rdata[0] == $past(core_power_on)) else $error("status readback wrong");
  cal_done_a: assert property (
    core_cal_run && core_cal_done |=> !core_cal_run) else $error("calibration not cleared");
  cont_run_a: assert property (
    core_conv_done && ctl_q[1] && core_power_on |=> core_conv_start) else $error("no restart");
  wake_up_a: assert property (
    wr_ctl && wdata[0] && !core_power_on |=> core_wake && core_power_on) else $error("no wake");
  rewrite_a: assert property (
    wr_ctl && wdata == ctl_q && core_power_on && !core_cal_init && !core_cal_run
      |=> core_conv_start) else $error("rewrite start lost");
endmodule
bind adc_conversion_control conv_ctl_chk chk (.mclk, .rst, .addr, .wdata, .wr_stb, .rd_stb,
  .rdata, .core_conv_done, .core_cal_init_done, .core_cal_done, .core_wake, .core_power_on,
  .core_conv_start, .core_cal_init, .core_cal_run, .dma_req);

//--- verification/core_model.sv
// behavioural converter core answering starts and calibration
`timescale 1ns/1ps
module core_model
#(
  parameter int LAT = 4 // answer delay, two or more
)
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic core_conv_start,
  input  wire logic core_cal_init,
  input  wire logic core_cal_run,
  output logic      core_conv_done,
  output logic      core_cal_init_done,
  output logic      core_cal_done
);
  int conv_q; // cycles since start, 0 idle
  int init_q; // cycles of init request
  int run_q;  // cycles of calibration request
  // counters restart per request so each done is a single pulse
  always_ff @(posedge mclk)
  begin
    conv_q <= rst ? 0 : core_conv_start ? 1 : (conv_q == 0 || conv_q == LAT) ? 0 : conv_q + 1;
    init_q <= (core_cal_init && !rst) ? init_q + 1 : 0;
    run_q  <= (core_cal_run && !rst) ? run_q + 1 : 0;
  end
  assign core_conv_done     = conv_q == LAT;
  assign core_cal_init_done = init_q == LAT;
  assign core_cal_done      = run_q == LAT;
endmodule

//--- verification/adc_conversion_control_tb.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ps
`include "conv_ctl_cfg.svh"
module adc_conversion_control_tb;
  import conv_ctl_pkg::*;
  logic mclk = 0, rst = 1, wr_stb = 0, rd_stb = 0;
  logic [7:0] addr = '0, trig_in = '0;
  word_t      wdata = '0, rdata;
  logic       core_wake, core_power_on, core_conv_start, core_cal_init, core_cal_run;
  logic       core_align_msb, core_temp_ref_en, dma_req;
  logic       core_conv_done, core_cal_init_done, core_cal_done;
  logic [2:0] core_sample_ch16, core_sample_ch17;
  int         n_errors = 0, total_checks = 0, cyc = 0, n_start = 0, n_dma = 0, s0, d0;
  initial forever #5 mclk = ~mclk;
  adc_conversion_control uut (.mclk, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .trig_in,
    .core_conv_done, .core_cal_init_done, .core_cal_done, .core_wake, .core_power_on,
    .core_conv_start, .core_cal_init, .core_cal_run, .core_align_msb, .core_temp_ref_en,
    .core_sample_ch16, .core_sample_ch17, .dma_req);
  core_model #(.LAT(4)) cm (.mclk, .rst, .core_conv_start, .core_cal_init, .core_cal_run,
    .core_conv_done, .core_cal_init_done, .core_cal_done);
  // pulse tallies and hang guard
  always @(posedge mclk)
  begin
    cyc++;
    n_start += (core_conv_start === 1'b1);
    n_dma += (dma_req === 1'b1);
    if (cyc == 3000)
    begin
      n_errors++;
      complete_run();
    end
  end
  task chk(input word_t seen, input word_t exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input word_t d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input word_t exp);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // #1 lets the tally of the last edge land first
  task cnt(input int n);
    s0 = n_start;
    d0 = n_dma;
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task complete_run();
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(`OFF_CTL_TWO, `RST_CTL_TWO);
    wr(`OFF_SAMPT_UPPER, '1);
    rd(`OFF_SAMPT_UPPER, `SAMPT_UPPER_MASK);
    chk(core_sample_ch16, 3'h7);
    chk(core_sample_ch17, 3'h7);
    rd(8'h04, '0);
    wr(`OFF_CTL_TWO, 32'h1);
    chk(core_wake, 1'b1);
    repeat (20) @(posedge mclk);
    wr(`OFF_CTL_TWO, 32'h1);
    chk(core_conv_start, 1'b1);
    wr(`OFF_CTL_TWO, 32'h9);
    rd(`OFF_CTL_TWO, 32'h9);
    for (int i = 0; i < 20 && core_cal_init === 1'b1; i++) @(posedge mclk);
    rd(`OFF_CTL_TWO, 32'h1);
    wr(`OFF_CTL_TWO, 32'h5);
    for (int i = 0; i < 20 && core_cal_run === 1'b1; i++) @(posedge mclk);
    rd(`OFF_CTL_TWO, 32'h1);
    wr(`OFF_CTL_TWO, 32'h004E_0101);
    cnt(12);
    chk(n_start - s0, 1);
    chk(n_dma - d0, 1);
    wr(`OFF_CTL_TWO, 32'h004E_0001);
    cnt(12);
    chk(n_dma - d0, 0);
    wr(`OFF_CTL_TWO, 32'h004E_0003);
    cnt(30);
    chk(n_start - s0 > 3, 1);
    wr(`OFF_CTL_TWO, 32'h1);
    cnt(12);
    chk(n_start - s0 < 2, 1);
    // every pin code; the reserved one must stay silent
    for (int c = 0; c < 7; c++)
    begin
      wr(`OFF_CTL_TWO, 32'h0010_0001 | (c << 17));
      @(posedge mclk) trig_in <= 8'h01 << c;
      cnt(12);
      @(posedge mclk) trig_in <= '0;
      chk(n_start - s0, c != 3);
    end
    wr(`OFF_CTL_TWO, 32'h0080_0801);
    chk(core_align_msb, 1'b1);
    chk(core_temp_ref_en, 1'b1);
    chk(core_power_on, 1'b1);
    rd(`OFF_CTL_TWO, 32'h0080_0801);
    // reset again in mid-run: every level returns to zero
    @(posedge mclk) rst <= 1'b1;
    @(posedge mclk) rst <= 1'b0;
    #1 chk(core_power_on, 1'b0);
    chk(core_align_msb, 1'b0);
    chk(core_sample_ch16, 3'h0);
    rd(`OFF_CTL_TWO, `RST_CTL_TWO);
    rd(`OFF_SAMPT_UPPER, `RST_SAMPT_UPPER);
    complete_run();
  end
endmodule
